// File: cgc_field_model.sv
// Field-side model: count pulses, gate inputs and bus-cycle sample instant.
`timescale 1ns/1ps
module cgc_field_model (
  // Clock
  input wire logic clk,
  // Field lines
  output logic count_up_pulse,
  output logic count_down_pulse,
  output logic gate_open_input,
  output logic gate_close_input,
  output logic cycle_sample_instant
);
  logic [4:0] lines;

  // ==========================================================================
  // Line drivers
  assign {cycle_sample_instant, gate_close_input, gate_open_input} = lines[4:2];
  assign {count_down_pulse, count_up_pulse} = lines[1:0];
  initial lines = 5'h00;

  // Holds each level for hold cycles so the input synchroniser sees it; hold sets speed.
  task automatic pulse(input int unsigned sel, input int unsigned n, input int unsigned hold);
    repeat (n) begin
      @(posedge clk);
      lines[sel] <= 1'b1;
      repeat (hold) @(posedge clk);
      lines[sel] <= 1'b0;
      repeat (hold) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
endmodule // cgc_field_model

// File: cgc_gate_compare.sv
// Counter with gate halt, isochronous software gate timing and two compare outputs behind AXI4-Lite.
`timescale 1ns/1ps
`include "cgc_map.svh"

module cgc_gate_compare #(
  parameter int unsigned MS_CYCLES = `CGC_CLK_KHZ * `CGC_PULSE_UNIT_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Field inputs
  input wire logic gate_open_input,
  input wire logic gate_close_input,
  input wire logic count_up_pulse,
  input wire logic count_down_pulse,
  input wire logic cycle_sample_instant,
  // Field outputs
  output logic compare_output_zero,
  output logic compare_output_one,
  output logic gate_event
);

  // ==========================================================================
  // Helpers
  function automatic logic cmp_ge(input logic [31:0] a, input logic [31:0] b, input logic sgn);
    cmp_ge = sgn ? ($signed(a) >= $signed(b)) : (a >= b);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        merge[k*8 +: 8] = d[k*8 +: 8];
      end
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:5] == 3'h0);
  endfunction

  // ==========================================================================
  // Input synchronisers
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] sync_c;
  logic [4:0] rise;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_c <= 5'h00;
    end else begin
      sync_a <= {cycle_sample_instant, count_down_pulse, count_up_pulse, gate_close_input,
                 gate_open_input};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end
  assign rise = sync_b & ~sync_c;

  // ==========================================================================
  // Bus and registers
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  cgc_pkg::cgc_ctrl_s ctrl, next_ctrl;
  cgc_pkg::cgc_mode_s mode, next_mode;
  logic [31:0] cmp_stage [2];
  logic [31:0] next_cmp_stage [2];
  logic [31:0] cmp [2];
  logic [31:0] next_cmp [2];
  logic [8:0] pulse_ms, next_pulse_ms;
  logic load_req;
  logic [31:0] load_val;
  logic do_write;
  logic [31:0] count, next_count;
  logic [31:0] status;

  assign s_axi_awready = ~aw_full & ~bvalid;
  assign s_axi_wready = ~w_full & ~bvalid;
  assign s_axi_arready = ~rvalid;
  assign do_write = aw_full & w_full & ~bvalid;

  always_comb begin
    logic [31:0] wv;
    wv = 32'h0000_0000;
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ctrl = ctrl;
    next_mode = mode;
    next_cmp_stage = cmp_stage;
    next_cmp = cmp;
    next_pulse_ms = pulse_ms;
    load_req = 1'b0;
    load_val = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(aw_addr) ? 2'h0 : 2'h2;
      case ({aw_addr[7:2], 2'h0})
        `CGC_ADDR_CTRL: begin
          next_ctrl = cgc_pkg::cgc_ctrl_s'(merge(ctrl, w_data, w_strb) & `CGC_CTRL_MASK);
        end
        `CGC_ADDR_MODE: begin
          next_mode = cgc_pkg::cgc_mode_s'(merge(mode, w_data, w_strb) & `CGC_MODE_MASK);
        end
        `CGC_ADDR_CMP1: begin
          next_cmp_stage[0] = merge(cmp_stage[0], w_data, w_strb);
        end
        `CGC_ADDR_CMP2: begin
          next_cmp_stage[1] = merge(cmp_stage[1], w_data, w_strb);
        end
        `CGC_ADDR_XFER: begin
          wv = merge(32'h0000_0000, w_data, w_strb);
          if (wv[`CGC_XFER_CMP1_BIT]) begin
            next_cmp[0] = cmp_stage[0];
          end
          if (wv[`CGC_XFER_CMP2_BIT]) begin
            next_cmp[1] = cmp_stage[1];
          end
        end
        `CGC_ADDR_PULSE: begin
          wv = merge({23'h000000, pulse_ms}, w_data, w_strb);
          next_pulse_ms = (wv > {23'h000000, `CGC_PULSE_MAX_MS}) ? `CGC_PULSE_MAX_MS
                          : wv[8:0];
        end
        `CGC_ADDR_COUNT: begin
          load_req = 1'b1;
          load_val = merge(count, w_data, w_strb);
        end
        default: begin
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      case ({s_axi_araddr[7:2], 2'h0})
        `CGC_ADDR_CTRL: next_rdata = ctrl;
        `CGC_ADDR_MODE: next_rdata = mode;
        `CGC_ADDR_CMP1: next_rdata = cmp_stage[0];
        `CGC_ADDR_CMP2: next_rdata = cmp_stage[1];
        `CGC_ADDR_PULSE: next_rdata = {23'h000000, pulse_ms};
        `CGC_ADDR_COUNT: next_rdata = count;
        `CGC_ADDR_STATUS: next_rdata = status;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
      ctrl <= `CGC_CTRL_RST;
      mode <= `CGC_MODE_RST;
      cmp_stage[0] <= `CGC_CMP_RST;
      cmp_stage[1] <= `CGC_CMP_RST;
      cmp[0] <= `CGC_CMP_RST;
      cmp[1] <= `CGC_CMP_RST;
      pulse_ms <= `CGC_PULSE_RST;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctrl <= next_ctrl;
      mode <= next_mode;
      cmp_stage <= next_cmp_stage;
      cmp <= next_cmp;
      pulse_ms <= next_pulse_ms;
    end
  end
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // ==========================================================================
  // Gate and counter
  logic halted, next_halted, soft_eff, next_soft_eff, hw_open, next_hw_open;
  logic gate_run, gate_prev, next_gate_event, event_q;
  logic gate_on, soft_rise, step, step_up;

  always_comb begin
    next_soft_eff = soft_eff;
    if (!ctrl.iso_mode || rise[4]) begin
      next_soft_eff = ctrl.soft_gate_ctl;
    end
    soft_rise = next_soft_eff & ~soft_eff;
    next_hw_open = hw_open;
    if (rise[1]) begin
      next_hw_open = 1'b0;
    end else if (rise[0] && !sync_b[1]) begin
      next_hw_open = 1'b1;
    end
    next_halted = halted;
    if (ctrl.gate_halt_request) begin
      next_halted = 1'b1;
    end else if ((ctrl.gate_sel == cgc_pkg::CGC_GATE_HARD) ? (rise[0] && !sync_b[1])
                 : (ctrl.gate_sel == cgc_pkg::CGC_GATE_SOFT) ? soft_rise : 1'b1) begin
      next_halted = 1'b0;
    end
    case (ctrl.gate_sel)
      cgc_pkg::CGC_GATE_SOFT: gate_on = soft_eff;
      cgc_pkg::CGC_GATE_HARD: gate_on = hw_open;
      default: gate_on = 1'b1;
    endcase
    gate_run = gate_on & ~halted & ~ctrl.gate_halt_request;
    next_gate_event = ctrl.gate_event_sel & (gate_run ^ gate_prev);
    step = gate_run & (rise[2] ^ rise[3]);
    step_up = rise[2];
    next_count = count;
    if (load_req) begin
      next_count = load_val;
    end else if (step) begin
      next_count = step_up ? count + 32'h0000_0001 : count - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halted <= 1'b0;
      soft_eff <= 1'b0;
      hw_open <= 1'b0;
      gate_prev <= 1'b1;
      event_q <= 1'b0;
      count <= 32'h0000_0000;
    end else begin
      halted <= next_halted;
      soft_eff <= next_soft_eff;
      hw_open <= next_hw_open;
      gate_prev <= gate_run;
      event_q <= next_gate_event;
      count <= next_count;
    end
  end
  assign gate_event = event_q;

  // ==========================================================================
  // Compare outputs
  logic pulse_on [2];
  logic next_pulse_on [2];
  logic [8:0] pulse_left [2];
  logic [8:0] next_pulse_left [2];
  logic [31:0] pulse_pre [2];
  logic [31:0] next_pulse_pre [2];
  logic [1:0] out_q, next_out;
  cgc_pkg::cgc_mode_e md [2];
  assign md[0] = mode.mode_zero;
  assign md[1] = mode.mode_one;

  always_comb begin
    logic reach;
    logic cond;
    logic sgn;
    reach = 1'b0;
    cond = 1'b0;
    sgn = ctrl.signed_range;
    next_pulse_on = pulse_on;
    next_pulse_left = pulse_left;
    next_pulse_pre = pulse_pre;
    next_out = 2'h0;
    for (int i = 0; i < 2; i++) begin
      // The pulse modes fire only on a counted step landing on the value.
      case (md[i])
        cgc_pkg::CGC_PULSE_UP: reach = step & step_up;
        cgc_pkg::CGC_PULSE_DOWN: reach = step & ~step_up;
        cgc_pkg::CGC_PULSE_BOTH: reach = step;
        default: reach = 1'b0;
      endcase
      reach = reach & (next_count == cmp[i]);
      if (!(i == 0 ? ctrl.output_zero_enable : ctrl.output_one_enable)) begin
        next_pulse_on[i] = 1'b0;
      end else if (reach) begin
        next_pulse_on[i] = 1'b1;
        next_pulse_left[i] = pulse_ms;
        next_pulse_pre[i] = 32'h0000_0000;
      end else if (pulse_on[i] && pulse_left[i] == 9'h000) begin
        if (step || load_req) begin
          next_pulse_on[i] = 1'b0;
        end
      end else if (pulse_on[i]) begin
        next_pulse_pre[i] = pulse_pre[i] + 32'h0000_0001;
        if (pulse_pre[i] >= MS_CYCLES - 1) begin
          next_pulse_pre[i] = 32'h0000_0000;
          next_pulse_left[i] = pulse_left[i] - 9'h001;
          if (pulse_left[i] == 9'h001) begin
            next_pulse_on[i] = 1'b0;
          end
        end
      end
      // Levels come from the updated count, so loads take effect too.
      case (md[i])
        cgc_pkg::CGC_INACTIVE: cond = (i == 0) ? ctrl.output_zero_force
                                      : ctrl.output_one_force;
        cgc_pkg::CGC_TO_OVERFLOW: cond = cmp_ge(next_count, cmp[i], sgn);
        cgc_pkg::CGC_TO_UNDERFLOW: cond = cmp_ge(cmp[i], next_count, sgn);
        cgc_pkg::CGC_PULSE_UP, cgc_pkg::CGC_PULSE_DOWN, cgc_pkg::CGC_PULSE_BOTH: begin
          cond = next_pulse_on[i];
        end
        cgc_pkg::CGC_BETWEEN: begin
          if (i == 0 || md[0] != cgc_pkg::CGC_INACTIVE) begin
            cond = 1'b0;
          end else if (cmp_ge(cmp[1], cmp[0], sgn)) begin
            cond = cmp_ge(next_count, cmp[0], sgn) & cmp_ge(cmp[1], next_count, sgn);
          end else begin
            cond = ~cmp_ge(next_count, cmp[1], sgn) | ~cmp_ge(cmp[0], next_count, sgn);
          end
        end
        default: cond = 1'b0;
      endcase
      if (i == 0 && md[1] == cgc_pkg::CGC_BETWEEN && md[0] == cgc_pkg::CGC_INACTIVE) begin
        cond = 1'b0;
      end
      next_out[i] = cond & ((i == 0) ? next_ctrl.output_zero_enable
                                     : next_ctrl.output_one_enable);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_on[0] <= 1'b0;
      pulse_on[1] <= 1'b0;
      pulse_left[0] <= 9'h000;
      pulse_left[1] <= 9'h000;
      pulse_pre[0] <= 32'h0000_0000;
      pulse_pre[1] <= 32'h0000_0000;
      out_q <= 2'h0;
    end else begin
      pulse_on <= next_pulse_on;
      pulse_left <= next_pulse_left;
      pulse_pre <= next_pulse_pre;
      out_q <= next_out;
    end
  end
  assign compare_output_zero = out_q[0];
  assign compare_output_one = out_q[1];

  always_comb begin
    status = 32'h0000_0000;
    status[`CGC_STAT_RUN_BIT] = gate_run;
    status[`CGC_STAT_HALTED_BIT] = halted;
    status[`CGC_STAT_OUT0_BIT] = out_q[0];
    status[`CGC_STAT_OUT1_BIT] = out_q[1];
    status[`CGC_STAT_SOFT_BIT] = soft_eff;
    status[`CGC_STAT_HW_BIT] = hw_open;
  end

endmodule // cgc_gate_compare

// File: cgc_gate_compare_properties.sv
// Checker for bus handshakes and output reset state of the gate and compare block.
`timescale 1ns/1ps
module cgc_checker #(
  parameter int unsigned MS_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Field outputs
  input wire logic compare_output_zero,
  input wire logic compare_output_one,
  input wire logic gate_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // Properties
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20 |=>
      s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_mapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr < 8'h20 |=> s_axi_rresp == 2'b00;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped read refused");
  property p_reset_out;
    $rose(arst_n) |-> !compare_output_zero && !compare_output_one && !gate_event;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("output active after reset");

  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_event: cover property (gate_event);
  c_both_out: cover property (compare_output_zero && compare_output_one);
endmodule // cgc_checker

bind cgc_gate_compare cgc_checker #(.MS_CYCLES(MS_CYCLES)) chk (.clk, .arst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .compare_output_zero, .compare_output_one, .gate_event);

// File: cgc_map.svh
// Register offsets, field positions, reset values and timing constants of the gate/compare block.
`ifndef CGC_MAP_SVH
`define CGC_MAP_SVH

// ==========================================================================
// Register byte offsets
`define CGC_ADDR_CTRL 8'h00
`define CGC_ADDR_MODE 8'h04
`define CGC_ADDR_CMP1 8'h08
`define CGC_ADDR_CMP2 8'h0C
`define CGC_ADDR_XFER 8'h10
`define CGC_ADDR_PULSE 8'h14
`define CGC_ADDR_COUNT 8'h18
`define CGC_ADDR_STATUS 8'h1C

// ==========================================================================
// Field positions
`define CGC_XFER_CMP1_BIT 0
`define CGC_XFER_CMP2_BIT 1
`define CGC_STAT_RUN_BIT 0
`define CGC_STAT_HALTED_BIT 1
`define CGC_STAT_OUT0_BIT 2
`define CGC_STAT_OUT1_BIT 3
`define CGC_STAT_SOFT_BIT 4
`define CGC_STAT_HW_BIT 5

// ==========================================================================
// Reset values and write masks
`define CGC_CTRL_RST 32'h0000_0000
`define CGC_CTRL_MASK 32'h0000_07FF
`define CGC_MODE_RST 32'h0000_0000
`define CGC_MODE_MASK 32'h0000_0077
`define CGC_PULSE_RST 9'h000
`define CGC_CMP_RST 32'h0000_0000

// ==========================================================================
// Timing
`define CGC_CLK_KHZ 50000
`define CGC_PULSE_UNIT_MS 1
`define CGC_PULSE_MAX_MS 9'h1F4

`endif

// File: cgc_pkg.sv
// Types shared by the gate/compare block: output behaviours, gate selection, register layouts.
package cgc_pkg;

  // ==========================================================================
  // Output behaviour and gate source
  typedef enum logic [2:0] {
    CGC_INACTIVE = 3'b000,
    CGC_TO_OVERFLOW = 3'b001,
    CGC_TO_UNDERFLOW = 3'b010,
    CGC_PULSE_UP = 3'b011,
    CGC_PULSE_DOWN = 3'b100,
    CGC_PULSE_BOTH = 3'b101,
    CGC_BETWEEN = 3'b110
  } cgc_mode_e;

  typedef enum logic [1:0] {
    CGC_GATE_NONE = 2'b00,
    CGC_GATE_SOFT = 2'b01,
    CGC_GATE_HARD = 2'b10
  } cgc_gate_e;

  // ==========================================================================
  // Register layouts
  typedef struct packed {
    logic [20:0] rsvd;
    logic gate_event_sel;
    cgc_gate_e gate_sel;
    logic signed_range;
    logic iso_mode;
    logic output_one_force;
    logic output_zero_force;
    logic output_one_enable;
    logic output_zero_enable;
    logic soft_gate_ctl;
    logic gate_halt_request;
  } cgc_ctrl_s;

  typedef struct packed {
    logic [24:0] rsvd;
    cgc_mode_e mode_one;
    logic rsvd_b;
    cgc_mode_e mode_zero;
  } cgc_mode_s;

endpackage

// File: test_counter_gate_compare_outputs.sv
// Self-checking bench for the gate and compare block.
`timescale 1ns/1ps
`include "cgc_map.svh"
module test_counter_gate_compare_outputs;
  logic clk, arst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic gate_open_input, gate_close_input, count_up_pulse, count_down_pulse;
  logic cycle_sample_instant, compare_output_zero, compare_output_one, gate_event;
  logic [33:0] exp_q[$];
  int bad_count, tests_run, ev;

  // ==========================================================================
  // Design, field model and clock
  cgc_gate_compare #(.MS_CYCLES(4)) uut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_open_input, .gate_close_input,
    .count_up_pulse, .count_down_pulse, .cycle_sample_instant, .compare_output_zero,
    .compare_output_one, .gate_event);
  cgc_field_model fld (.clk, .count_up_pulse, .count_down_pulse, .gate_open_input,
    .gate_close_input, .cycle_sample_instant);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Checking, bus tasks and monitor
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, bv, go;
    go = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (go) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      bv = s_axi_bvalid;
      tb = bv & s_axi_bready;
      if (tb) chk("write response", s_axi_bresp, (a >= 8'h20) ? 2'b10 : 2'b00);
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv & !tb;
      go = !tb;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic ta, tr, rv, go;
    go = 1'b1;
    exp_q.push_back({(a >= 8'h20) ? 2'b10 : 2'b00, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (go) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      tr = rv & s_axi_rready;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv & !tr;
      go = !tr;
    end
  endtask

  task automatic outs(input logic e0, input logic e1);
    @(negedge clk);
    chk("output zero", compare_output_zero, e0);
    chk("output one", compare_output_one, e1);
    @(posedge clk);
  endtask

  always @(negedge clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (gate_event === 1'b1) ev++;
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    bad_count++;
    complete_run();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'hd825));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(`CGC_ADDR_CTRL, `CGC_CTRL_RST);
    rd(`CGC_ADDR_MODE, `CGC_MODE_RST);
    rd(`CGC_ADDR_PULSE, 32'h0);
    rd(`CGC_ADDR_STATUS, 32'h1);
    rd(8'h20, 32'h0);
    wr(8'h24, 32'h5);
    fld.pulse(0, 3, 2);
    rd(`CGC_ADDR_COUNT, 32'h3);
    wr(`CGC_ADDR_CTRL, 32'h1);
    fld.pulse(0, 2, 4);
    rd(`CGC_ADDR_COUNT, 32'h3);
    rd(`CGC_ADDR_STATUS, 32'h2);
    wr(`CGC_ADDR_CTRL, 32'h201);
    wr(`CGC_ADDR_CTRL, 32'h200);
    fld.pulse(0, 2, 2);
    rd(`CGC_ADDR_COUNT, 32'h3);
    fld.pulse(2, 1, 2);
    fld.pulse(0, 2, 2);
    rd(`CGC_ADDR_COUNT, 32'h5);
    wr(`CGC_ADDR_CTRL, 32'h640);
    ev = 0;
    fld.pulse(3, 1, 2);
    fld.pulse(0, 2, 2);
    rd(`CGC_ADDR_COUNT, 32'h5);
    fld.pulse(2, 1, 2);
    fld.pulse(0, 1, 2);
    rd(`CGC_ADDR_COUNT, 32'h6);
    chk("gate events", ev, 2);
    wr(`CGC_ADDR_CTRL, 32'h140);
    wr(`CGC_ADDR_CTRL, 32'h142);
    fld.pulse(0, 2, 2);
    rd(`CGC_ADDR_COUNT, 32'h6);
    fld.pulse(4, 1, 2);
    fld.pulse(0, 1, 2);
    rd(`CGC_ADDR_COUNT, 32'h7);
    for (int m = 0; m < 8; m++) begin
      wr(`CGC_ADDR_MODE, 32'h11 * m);
      rd(`CGC_ADDR_MODE, 32'h11 * m);
    end
    // Output zero to overflow and output one to underflow, then signed range, force bits and pulse width.
    wr(`CGC_ADDR_CTRL, 32'h0);
    wr(`CGC_ADDR_COUNT, 32'hA);
    wr(`CGC_ADDR_CMP1, 32'hC);
    wr(`CGC_ADDR_CMP2, 32'h8);
    wr(`CGC_ADDR_MODE, 32'h21);
    wr(`CGC_ADDR_XFER, 32'h3);
    wr(`CGC_ADDR_CTRL, 32'hC);
    rd(`CGC_ADDR_COUNT, 32'hA);
    outs(1'b0, 1'b0);
    fld.pulse(0, 2, 2);
    outs(1'b1, 1'b0);
    fld.pulse(1, 1, 4);
    outs(1'b0, 1'b0);
    wr(`CGC_ADDR_COUNT, 32'h5);
    outs(1'b0, 1'b1);
    wr(`CGC_ADDR_CMP1, 32'hFFFF_FFFF);
    wr(`CGC_ADDR_XFER, 32'h1);
    outs(1'b0, 1'b1);
    wr(`CGC_ADDR_CTRL, 32'h8C);
    outs(1'b1, 1'b1);
    wr(`CGC_ADDR_MODE, 32'h0);
    wr(`CGC_ADDR_CTRL, 32'h3C);
    outs(1'b1, 1'b1);
    fld.pulse(0, 1, 2);
    outs(1'b1, 1'b1);
    wr(`CGC_ADDR_CTRL, 32'h1C);
    outs(1'b1, 1'b0);
    wr(`CGC_ADDR_CTRL, 32'h34);
    outs(1'b1, 1'b0);
    wr(`CGC_ADDR_CMP1, 32'h7);
    wr(`CGC_ADDR_XFER, 32'h1);
    wr(`CGC_ADDR_MODE, 32'h3);
    wr(`CGC_ADDR_CTRL, 32'h4);
    wr(`CGC_ADDR_COUNT, 32'h6);
    outs(1'b0, 1'b0);
    fld.pulse(0, 1, 2);
    outs(1'b1, 1'b0);
    fld.pulse(0, 1, 2);
    outs(1'b0, 1'b0);
    wr(`CGC_ADDR_PULSE, 32'h258);
    rd(`CGC_ADDR_PULSE, 32'h1F4);
    wr(`CGC_ADDR_PULSE, 32'h2);
    wr(`CGC_ADDR_COUNT, 32'h6);
    fld.pulse(0, 1, 2);
    outs(1'b1, 1'b0);
    repeat (10) @(posedge clk);
    outs(1'b0, 1'b0);
    wr(`CGC_ADDR_PULSE, 32'h1F4);
    wr(`CGC_ADDR_COUNT, 32'h6);
    fld.pulse(0, 1, 2);
    outs(1'b1, 1'b0);
    wr(`CGC_ADDR_CTRL, 32'h0);
    outs(1'b0, 1'b0);
    // Output one between two values, then output zero pulsing on a downward step.
    wr(`CGC_ADDR_CMP1, 32'h5);
    wr(`CGC_ADDR_CMP2, 32'h9);
    wr(`CGC_ADDR_XFER, 32'h3);
    wr(`CGC_ADDR_MODE, 32'h60);
    wr(`CGC_ADDR_CTRL, 32'hC);
    wr(`CGC_ADDR_COUNT, 32'h7);
    outs(1'b0, 1'b1);
    wr(`CGC_ADDR_COUNT, 32'hA);
    outs(1'b0, 1'b0);
    wr(`CGC_ADDR_MODE, 32'h4);
    wr(`CGC_ADDR_PULSE, 32'h0);
    wr(`CGC_ADDR_COUNT, 32'h6);
    fld.pulse(1, 1, 2);
    outs(1'b1, 1'b0);
    fld.pulse(1, 1, 2);
    outs(1'b0, 1'b0);
    r = $urandom();
    wr(`CGC_ADDR_CMP2, r);
    rd(`CGC_ADDR_CMP2, r);
    r = $urandom();
    wr(`CGC_ADDR_COUNT, r);
    rd(`CGC_ADDR_COUNT, r);
    wr(`CGC_ADDR_XFER, 32'h3);
    rd(`CGC_ADDR_XFER, 32'h0);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule // test_counter_gate_compare_outputs
